// [sdbc_core.sv]
// burst, mask and suspend control of a two-bank sdram, apb registers
`timescale 1ns/100ps
`default_nettype none
`include "sdbc_defs.svh"

// Summary of operation
// - read precharge stops output after cas latency
// - write precharge stops storing in same cycle
// - other-bank precharge leaves write burst running
// - full-page read wraps after 256 columns
// - full-page write wraps; stop or precharge ends it
// - read stop drives cas-latency more cycles
// - write stop ends storing immediately
// - read mask tristates lane two cycles later
// - upper mask high byte, lower mask low
// - read mask leaves burst counter running
// - write mask drops lane data same cycle
// - write mask leaves burst counter running
// - single-write mode stores one word per write
// - low clock enable freezes state and inputs
// - resume next edge; controller waits recovery
// - precharge one bank or both by select
// - first read word after cas latency
module sdbc_core
  import sdbc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clk_enable,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [11:0] addr,
  input wire logic upper_byte_mask,
  input wire logic lower_byte_mask,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic [1:0] dq_oe
);

  // -----------------------------------------------
  // state
  // -----------------------------------------------
  typedef struct packed {
    sdbc_pin_s p1;
    sdbc_pin_s p2;
    logic cke_q;
    sdbc_burst_e bst;
    logic bank;
    logic [7:0] start;
    logic [7:0] cnt;
    logic [1:0] act;
    logic rv;
    logic q1v;
    logic [15:0] q1d;
    logic [1:0] mk1;
    logic [15:0] dq_out;
    logic [1:0] dq_oe;
    logic cl3;
    logic [2:0] bl;
    logic sw;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } sdbc_state_s;

  sdbc_state_s st_r;
  sdbc_state_s st_nxt;

  logic mem_re;
  logic [8:0] mem_raddr;
  logic [1:0] mem_we;
  logic [8:0] mem_waddr;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;

  // -----------------------------------------------
  // functions
  // -----------------------------------------------
  function automatic sdbc_cmd_e cmd_decode(input sdbc_pin_s p);
    sdbc_cmd_e c;
    c = SDBC_C_NOP;
    if (!p.cs_n) begin
      case ({p.ras_n, p.cas_n, p.we_n})
        3'h3: c = SDBC_C_ACT;
        3'h5: c = SDBC_C_READ;
        3'h4: c = SDBC_C_WRITE;
        3'h2: c = SDBC_C_PRE;
        3'h6: c = SDBC_C_STOP;
        default: c = SDBC_C_NOP;
      endcase
    end
    return c;
  endfunction

  function automatic logic [7:0] wrap_mask(input logic [2:0] bl);
    logic [7:0] m;
    m = `SDBC_M_FULL;
    case (bl)
      `SDBC_BL_1: m = `SDBC_M_1;
      `SDBC_BL_2: m = `SDBC_M_2;
      `SDBC_BL_4: m = `SDBC_M_4;
      `SDBC_BL_8: m = `SDBC_M_8;
      default: m = `SDBC_M_FULL;
    endcase
    return m;
  endfunction

  function automatic logic is_reg(input logic [11:0] a);
    return (a == `SDBC_CTRL_OFS) || (a == `SDBC_STAT_OFS);
  endfunction

  // -----------------------------------------------
  // storage
  // -----------------------------------------------
  sdbc_mem u_mem (
    .clk(pclk),
    .re(mem_re),
    .raddr(mem_raddr),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // -----------------------------------------------
  // next state
  // -----------------------------------------------
  always_comb begin
    sdbc_cmd_e cmd;
    logic hold;
    logic pre_hit;
    logic stop;
    logic new_rd;
    logic new_wr;
    logic rd_go;
    logic wr_go;
    logic bank;
    logic [7:0] start;
    logic [7:0] cnt;
    logic [7:0] m;
    logic [7:0] col;
    logic full;
    logic last;
    logic v;
    logic [15:0] d;
    logic [31:0] rd;
    cmd = SDBC_C_NOP;
    hold = 1'b0;
    pre_hit = 1'b0;
    stop = 1'b0;
    new_rd = 1'b0;
    new_wr = 1'b0;
    rd_go = 1'b0;
    wr_go = 1'b0;
    bank = 1'b0;
    start = `SDBC_CNT_ZERO;
    cnt = `SDBC_CNT_ZERO;
    m = `SDBC_M_FULL;
    col = `SDBC_CNT_ZERO;
    full = 1'b0;
    last = 1'b0;
    v = 1'b0;
    d = 16'h0000;
    rd = 32'h0000_0000;
    st_nxt = st_r;
    mem_re = 1'b0;
    mem_we = 2'h0;

    // pin synchronisers
    st_nxt.p1 = {clk_enable, cs_n, ras_n, cas_n, we_n, addr,
                 upper_byte_mask, lower_byte_mask, dq_in};
    st_nxt.p2 = st_r.p1;
    st_nxt.cke_q = st_r.p2.clk_enable;

    // command decode
    hold = !st_r.cke_q;
    cmd = cmd_decode(st_r.p2);
    pre_hit = (cmd == SDBC_C_PRE) &&
              (st_r.p2.addr[`SDBC_A_PALL] ||
               st_r.p2.addr[`SDBC_A_BANK] == st_r.bank);
    stop = (cmd == SDBC_C_STOP) || pre_hit;
    new_rd = !hold && cmd == SDBC_C_READ;
    new_wr = !hold && cmd == SDBC_C_WRITE;
    rd_go = new_rd || (!hold && !stop && !new_wr &&
                       st_r.bst == SDBC_B_READ);
    wr_go = new_wr || (!hold && !stop && !new_rd &&
                       st_r.bst == SDBC_B_WRITE);

    // burst address
    bank = (new_rd || new_wr) ? st_r.p2.addr[`SDBC_A_BANK] : st_r.bank;
    start = (new_rd || new_wr) ? st_r.p2.addr[`SDBC_A_COL_HI:0]
                               : st_r.start;
    cnt = (new_rd || new_wr) ? `SDBC_CNT_ZERO : st_r.cnt;
    m = (wr_go && st_r.sw) ? `SDBC_M_1 : wrap_mask(st_r.bl);
    full = (m == `SDBC_M_FULL);
    col = (start & ~m) | (8'(start + cnt) & m);
    last = !full && ((cnt & m) == m);

    // memory access
    mem_re = rd_go;
    mem_raddr = {bank, col};
    mem_waddr = {bank, col};
    mem_wdata = st_r.p2.dq;
    if (wr_go) begin
      mem_we = ~st_r.p2.mask;
    end

    if (!hold) begin
      // burst sequencing
      if (rd_go || wr_go) begin
        st_nxt.bst = rd_go ? SDBC_B_READ : SDBC_B_WRITE;
        st_nxt.bank = bank;
        st_nxt.start = start;
        st_nxt.cnt = 8'(cnt + `SDBC_CNT_ONE);
        if (last) begin
          st_nxt.bst = SDBC_B_IDLE;
        end
      end else if (stop) begin
        st_nxt.bst = SDBC_B_IDLE;
      end

      // bank activity
      if (cmd == SDBC_C_ACT) begin
        st_nxt.act[st_r.p2.addr[`SDBC_A_BANK]] = 1'b1;
      end else if (cmd == SDBC_C_PRE) begin
        if (st_r.p2.addr[`SDBC_A_PALL]) begin
          st_nxt.act = 2'h0;
        end else begin
          st_nxt.act[st_r.p2.addr[`SDBC_A_BANK]] = 1'b0;
        end
      end

      // read data pipeline
      st_nxt.rv = rd_go;
      st_nxt.q1v = st_r.rv;
      st_nxt.q1d = mem_rdata;
      st_nxt.mk1 = st_r.p2.mask;
      v = st_r.cl3 ? st_r.q1v : st_r.rv;
      d = st_r.cl3 ? st_r.q1d : mem_rdata;
      if (v) begin
        st_nxt.dq_out = d;
      end
      st_nxt.dq_oe = {2{v}} & ~st_r.mk1;
    end

    // apb slave, one wait state
    st_nxt.pready = 1'b0;
    if (psel && penable && !st_r.pready) begin
      st_nxt.pready = 1'b1;
      st_nxt.pslverr = !is_reg(paddr);
      if (paddr == `SDBC_CTRL_OFS) begin
        rd[`SDBC_F_CL3] = st_r.cl3;
        rd[`SDBC_F_BL_HI:`SDBC_F_BL_LO] = st_r.bl;
        rd[`SDBC_F_SW] = st_r.sw;
      end else if (paddr == `SDBC_STAT_OFS) begin
        rd[`SDBC_S_ACT_HI:`SDBC_S_ACT_LO] = st_r.act;
        rd[`SDBC_S_RD] = st_r.bst == SDBC_B_READ;
        rd[`SDBC_S_WR] = st_r.bst == SDBC_B_WRITE;
        rd[`SDBC_S_SUSP] = hold;
      end
      st_nxt.prdata = pwrite ? 32'h0000_0000 : rd;
    end
    if (psel && penable && st_r.pready && pwrite &&
        paddr == `SDBC_CTRL_OFS) begin
      st_nxt.cl3 = pwdata[`SDBC_F_CL3];
      st_nxt.bl = pwdata[`SDBC_F_BL_HI:`SDBC_F_BL_LO];
      st_nxt.sw = pwdata[`SDBC_F_SW];
    end
  end

  // -----------------------------------------------
  // registers
  // -----------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.p1.clk_enable <= 1'b1;
      st_r.p2.clk_enable <= 1'b1;
      st_r.cke_q <= 1'b1;
      st_r.p1.cs_n <= 1'b1;
      st_r.p2.cs_n <= 1'b1;
      st_r.bst <= SDBC_B_IDLE;
      st_r.cl3 <= `SDBC_CL3_RST;
      st_r.bl <= `SDBC_BL_RST;
      st_r.sw <= `SDBC_SW_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // -----------------------------------------------
  // outputs
  // -----------------------------------------------
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign dq_out = st_r.dq_out;
  assign dq_oe = st_r.dq_oe;

endmodule
`default_nettype wire

// [sdbc_ctl_model.sv]
// controller model driving the command pins
`timescale 1ns/100ps
`default_nettype none
module sdbc_ctl_model
  import sdbc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input var sdbc_cmd_e c,
  input wire logic [11:0] a,
  input wire logic [15:0] d,
  input wire logic drv,
  input wire logic [1:0] m,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [11:0] addr,
  output logic upper_byte_mask,
  output logic lower_byte_mask,
  output logic [15:0] dq_in
);
  logic [15:0] last_r;
  always_comb begin
    cs_n = c == SDBC_C_NOP;
    case (c)
      SDBC_C_ACT: {ras_n, cas_n, we_n} = 3'h3;
      SDBC_C_READ: {ras_n, cas_n, we_n} = 3'h5;
      SDBC_C_WRITE: {ras_n, cas_n, we_n} = 3'h4;
      SDBC_C_PRE: {ras_n, cas_n, we_n} = 3'h2;
      SDBC_C_STOP: {ras_n, cas_n, we_n} = 3'h6;
      default: {ras_n, cas_n, we_n} = 3'h7;
    endcase
  end
  assign addr = a;
  assign {upper_byte_mask, lower_byte_mask} = m;
  // released bus shows the inverse of its last value
  assign dq_in = drv ? d : ~last_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      last_r <= 16'h0;
    else if (drv)
      last_r <= d;
  end
endmodule
`default_nettype wire

// [sdbc_defs.svh]
// constants for the burst control block
`ifndef SDBC_DEFS_SVH
`define SDBC_DEFS_SVH

// -----------------------------------------------
// register map
// -----------------------------------------------
`define SDBC_CTRL_OFS 12'h000
`define SDBC_STAT_OFS 12'h004
`define SDBC_ADDR_LO 2

// -----------------------------------------------
// control fields and reset values
// -----------------------------------------------
`define SDBC_F_CL3 0
`define SDBC_F_BL_LO 1
`define SDBC_F_BL_HI 3
`define SDBC_F_SW 4
`define SDBC_CL3_RST 1'b1
`define SDBC_BL_RST 3'h3
`define SDBC_SW_RST 1'b0

// -----------------------------------------------
// status fields
// -----------------------------------------------
`define SDBC_S_ACT_LO 0
`define SDBC_S_ACT_HI 1
`define SDBC_S_RD 2
`define SDBC_S_WR 3
`define SDBC_S_SUSP 4

// -----------------------------------------------
// burst length codes and wrap masks
// -----------------------------------------------
`define SDBC_BL_1 3'h0
`define SDBC_BL_2 3'h1
`define SDBC_BL_4 3'h2
`define SDBC_BL_8 3'h3
`define SDBC_BL_FULL 3'h7
`define SDBC_M_1 8'h00
`define SDBC_M_2 8'h01
`define SDBC_M_4 8'h03
`define SDBC_M_8 8'h07
`define SDBC_M_FULL 8'hFF

// -----------------------------------------------
// pin address fields
// -----------------------------------------------
`define SDBC_A_COL_HI 7
`define SDBC_A_PALL 10
`define SDBC_A_BANK 11
`define SDBC_CNT_ZERO 8'h00
`define SDBC_CNT_ONE 8'h01

`endif

// [sdbc_mem.sv]
// two byte lanes of column storage, registered read
`timescale 1ns/100ps
`default_nettype none

module sdbc_mem (
  input wire logic clk,
  input wire logic re,
  input wire logic [8:0] raddr,
  input wire logic [1:0] we,
  input wire logic [8:0] waddr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);

  // -----------------------------------------------
  // one array per byte lane
  // -----------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_lane
      logic [7:0] arr [0:511];
      logic [7:0] rd_r;
      always_ff @(posedge clk) begin
        if (we[g]) begin
          arr[waddr] <= wdata[g*8 +: 8];
        end
        if (re) begin
          rd_r <= arr[raddr];
        end
      end
    end
  endgenerate

  assign rdata = {g_lane[1].rd_r, g_lane[0].rd_r};

endmodule
`default_nettype wire

// [sdbc_pkg.sv]
// types for the burst control block
package sdbc_pkg;

  typedef enum logic [2:0] {
    SDBC_C_NOP,
    SDBC_C_ACT,
    SDBC_C_READ,
    SDBC_C_WRITE,
    SDBC_C_PRE,
    SDBC_C_STOP
  } sdbc_cmd_e;

  typedef enum logic [1:0] {
    SDBC_B_IDLE,
    SDBC_B_READ,
    SDBC_B_WRITE
  } sdbc_burst_e;

  typedef struct packed {
    logic clk_enable;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [11:0] addr;
    logic [1:0] mask;
    logic [15:0] dq;
  } sdbc_pin_s;

endpackage

// [sdbc_properties.sv]
// port assertions of the burst control block
`timescale 1ns/100ps
`default_nettype none
`include "sdbc_defs.svh"
module sdbc_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic clk_enable,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [11:0] addr,
  input wire logic upper_byte_mask,
  input wire logic lower_byte_mask,
  input wire logic [15:0] dq_in,
  input wire logic [15:0] dq_out,
  input wire logic [1:0] dq_oe
);
  logic cl3_r;
  logic [3:0] cmd;
  logic ok, rd, pre, stp, mu, ml, nm;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign rd = clk_enable && cmd == 4'h5;
  assign pre = clk_enable && cmd == 4'h2 && addr[`SDBC_A_PALL];
  assign stp = clk_enable && cmd == 4'h6;
  assign mu = clk_enable && upper_byte_mask;
  assign ml = clk_enable && lower_byte_mask;
  assign nm = !upper_byte_mask && !lower_byte_mask;
  assign ok = paddr == `SDBC_CTRL_OFS || paddr == `SDBC_STAT_OFS;
  // cas latency seen by software writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cl3_r <= `SDBC_CL3_RST;
    else if (psel && penable && pready && pwrite && paddr == `SDBC_CTRL_OFS)
      cl3_r <= pwdata[`SDBC_F_CL3];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_one_wait: assert property (
    $rose(penable) && psel |=> pready ##1 !pready) else $error("bad pready");
  a_err_unmapped: assert property (
    pready && !ok |-> pslverr && prdata == 32'h0) else $error("no slverr");
  a_err_mapped: assert property (
    pready && ok |-> !pslverr) else $error("false slverr");
  a_read_first_word: assert property (
    rd && nm ##1 nm |-> if (cl3_r) ##4 dq_oe == 2'h3 else ##3 dq_oe == 2'h3)
    else $error("first word late");
  a_pre_ends_read: assert property (
    pre |-> if (cl3_r) ##5 dq_oe == 2'h0 else ##4 dq_oe == 2'h0)
    else $error("read not ended by precharge");
  a_stop_ends_read: assert property (
    stp |-> if (cl3_r) ##5 dq_oe == 2'h0 else ##4 dq_oe == 2'h0)
    else $error("read not ended by stop");
  a_mask_upper_lane: assert property (
    mu && $past(clk_enable) |-> ##4 !dq_oe[1])
    else $error("upper lane driven");
  a_mask_lower_lane: assert property (
    ml && $past(clk_enable) |-> ##4 !dq_oe[0])
    else $error("lower lane driven");
  a_suspend_holds: assert property (
    !clk_enable [*6] |-> $stable(dq_out) && $stable(dq_oe))
    else $error("outputs moved in suspend");
  c_read: cover property (rd ##4 dq_oe == 2'h3);
  c_pre_all: cover property (pre);
  c_suspend: cover property (!clk_enable [*6]);
endmodule
`default_nettype wire

// [tb_sdram_burst_interrupt_control.sv]
// testbench of the burst control block
`timescale 1ns/100ps
`default_nettype none
`include "sdbc_defs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("Error %0t: got %h exp %h", $time, g, e); end end
module tb_sdram_burst_interrupt_control
  import sdbc_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, clk_enable = 1'b1, drv = 1'b0;
  logic pready, pslverr, cs_n, ras_n, cas_n, we_n, er;
  logic upper_byte_mask, lower_byte_mask;
  logic [11:0] paddr = 12'h0, a = 12'h0, addr;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic [15:0] d = 16'h0, dq_in, dq_out;
  logic [1:0] m = 2'h0, dq_oe;
  logic [15:0] mem [0:511];
  logic [1:0] msk [0:511];
  sdbc_cmd_e c = SDBC_C_NOP;
  int fails = 0, n_tests = 0, cl = 3, bl = 8, sw = 0;
  bit act [2];
  sdbc_core uut (.*);
  sdbc_ctl_model u_ctl (.*);
  always #50 pclk = ~pclk;
  task automatic stop_test();
    $display("checks %0d errors %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input int wd);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {er, rv} = {pslverr, prdata};
    {psel, penable} <= 2'h0;
  endtask
  task automatic pin(sdbc_cmd_e cc, logic [11:0] aa, logic dv, logic [1:0] mm,
                     logic [15:0] dd = 16'($urandom));
    @(posedge pclk);
    {c, a, d, drv, m} <= {cc, aa, dd, dv, mm};
    @(negedge pclk);
  endtask
  function automatic logic [7:0] bc(logic [7:0] s, int i);
    return (s & ~8'(bl - 1)) | (8'(s + i) & 8'(bl - 1));
  endfunction
  task automatic opn(bit b, sdbc_cmd_e tc, logic [1:0] ta);
    if (tc == SDBC_C_PRE && ta[0])
      act = '{1'b0, 1'b0};
    else if (tc == SDBC_C_PRE)
      act[ta[1]] = 1'b0;
    if (!act[b]) begin
      pin(SDBC_C_ACT, {b, 11'h0}, 1'b0, 2'h0);
      repeat (3) pin(SDBC_C_NOP, 12'h0, 1'b0, 2'h0);
      act[b] = 1'b1;
    end
  endtask
  task automatic wr(bit b, logic [7:0] s, int n, sdbc_cmd_e tc, int tj,
                    logic [1:0] ta, bit rm);
    logic [15:0] dd;
    logic [1:0] mm;
    bit h;
    opn(b, SDBC_C_NOP, 2'h0);
    h = 0;
    for (int i = 0; i < n; i++) begin
      dd = 16'($urandom);
      mm = (i == tj && tc == SDBC_C_PRE) ? 2'h3 : rm ? 2'($urandom) : 2'h0;
      if (i == tj)
        h = tc == SDBC_C_STOP || ta[0] || ta[1] == b;
      pin(i == tj ? tc : i ? SDBC_C_NOP : SDBC_C_WRITE,
          i == tj ? {ta, 10'h0} : {b, 3'h0, s}, 1'b1, mm, dd);
      if (!h && i < (sw ? 1 : bl == 256 ? n : bl)) begin
        if (!mm[0]) mem[{b, bc(s, i)}][7:0] = dd[7:0];
        if (!mm[1]) mem[{b, bc(s, i)}][15:8] = dd[15:8];
      end
    end
    pin(SDBC_C_NOP, 12'h0, 1'b0, 2'h0);
    opn(b, tc, ta);
  endtask
  task automatic rd(bit b, logic [7:0] s, sdbc_cmd_e tc, int tj,
                    logic [1:0] ta, bit rm);
    int nw, i;
    logic [8:0] ix;
    opn(b, SDBC_C_NOP, 2'h0);
    nw = (tj >= 0 && (tc == SDBC_C_STOP || ta[0] || ta[1] == b)
          && (bl == 256 || tj < bl)) ? tj + 1 : bl;
    for (int k = 0; k < nw; k++)
      msk[k] = (rm && k + cl >= 3) ? 2'($urandom) : 2'h0;
    pin(SDBC_C_READ, {b, 3'h0, s}, 1'b0, 2'h0);
    for (int j = 0; j <= nw + cl + 1; j++) begin
      i = j + 3 - cl;
      pin(j == tj ? tc : SDBC_C_NOP, {ta, 10'h0}, 1'b0,
          i < nw ? msk[i] : 2'h0);
      i = j - 1 - cl;
      ix = {b, bc(s, i)};
      if (i >= 0) begin
        `CHK(dq_oe, i < nw ? ~msk[i] : 2'h0)
        if (i < nw && !msk[i][0])
          `CHK(dq_out[7:0], mem[ix][7:0])
        if (i < nw && !msk[i][1])
          `CHK(dq_out[15:8], mem[ix][15:8])
      end
    end
    opn(b, tc, ta);
  endtask
  initial begin
    void'($urandom(32'h56EB));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SDBC_CTRL_OFS, 0);
    `CHK({er, rv}, 33'h7)
    apb(1'b1, 12'h008, 1);
    `CHK({er, rv}, 33'h1_0000_0000)
    for (int q = 3; q >= 2; q--) begin
      cl = q;
      apb(1'b1, `SDBC_CTRL_OFS, q == 3 ? 32'h7 : 32'h6);
      wr(0, 8'h10, 8, SDBC_C_NOP, -1, 2'h0, 0);
      wr(0, 8'h13, 8, SDBC_C_NOP, -1, 2'h0, 1);
      rd(0, 8'h10, SDBC_C_NOP, -1, 2'h0, 1);
      rd(0, 8'h15, SDBC_C_PRE, 3, {1'b0, q == 2}, 0);
      rd(0, 8'h12, SDBC_C_STOP, 2, 2'h0, 0);
      wr(0, 8'h10, 8, SDBC_C_PRE, 5, 2'h0, 0);
      wr(0, 8'h10, 8, SDBC_C_PRE, 3, 2'h2, 1);
      wr(0, 8'h14, 8, SDBC_C_STOP, 2, 2'h0, 0);
      rd(0, 8'h10, SDBC_C_NOP, -1, 2'h0, 1);
    end
    apb(1'b1, `SDBC_CTRL_OFS, 32'hE);
    bl = 256;
    wr(1, 8'hFA, 261, SDBC_C_STOP, 260, 2'h0, 0);
    rd(1, 8'hFA, SDBC_C_STOP, 259, 2'h0, 1);
    pin(SDBC_C_PRE, 12'h800, 1'b0, 2'h3);
    opn(0, SDBC_C_PRE, 2'h2);
    apb(1'b1, `SDBC_CTRL_OFS, 32'h16);
    {bl, sw} = {32'd8, 32'd1};
    wr(0, 8'h10, 4, SDBC_C_NOP, -1, 2'h0, 0);
    rd(0, 8'h10, SDBC_C_NOP, -1, 2'h0, 1);
    pin(SDBC_C_READ, 12'h010, 1'b0, 2'h0);
    repeat (6) pin(SDBC_C_NOP, 12'h0, 1'b0, 2'h0);
    @(posedge pclk);
    clk_enable <= 1'b0;
    repeat (8) pin(SDBC_C_READ, 12'h018, 1'b0, 2'h3);
    apb(1'b0, `SDBC_STAT_OFS, 0);
    `CHK(rv[`SDBC_S_SUSP], 1'b1)
    clk_enable <= 1'b1;
    repeat (12) pin(SDBC_C_NOP, 12'h0, 1'b0, 2'h0);
    apb(1'b0, `SDBC_STAT_OFS, 0);
    `CHK(rv[`SDBC_S_SUSP], 1'b0)
    rd(0, 8'h10, SDBC_C_NOP, -1, 2'h0, 0);
    stop_test();
  end
  initial begin
    #5000000;
    fails++;
    stop_test();
  end
endmodule
bind sdbc_core sdbc_properties u_chk (.*);
`default_nettype wire
